// File: inc/psb_pkg.sv
package psb_pkg;
	// ****************************************
	// Sizes
	// ****************************************
	localparam int          NUM_CH       = 12;
	localparam int          NUM_BANK     = 4;
	localparam int          CH_PER_BANK  = 3;
	localparam int          CNT_W        = 10;
	localparam logic [9:0]  CNT_MAX      = 10'h3ff;
	localparam logic [9:0]  WIDTH_FULL   = 10'h3ff;
	localparam logic [9:0]  WIDTH_ZERO   = 10'h000;

	// ****************************************
	// Register map
	// ****************************************
	localparam logic [7:0]  ADDR_CH_END  = 8'h30;
	localparam logic [1:0]  FLD_PH_LO    = 2'h0;
	localparam logic [1:0]  FLD_PH_HI    = 2'h1;
	localparam logic [1:0]  FLD_WD_LO    = 2'h2;
	localparam logic [1:0]  FLD_WD_HI    = 2'h3;
	localparam logic [7:0]  ADDR_PAR     = 8'h71;
	localparam logic [7:0]  ADDR_EN_LO   = 8'h78;
	localparam logic [7:0]  ADDR_EN_HI   = 8'h79;
	localparam logic [7:0]  ADDR_CLKMODE = 8'h7c;
	localparam logic [7:0]  ADDR_SYSTEM_CONFIGURATION  = 8'h80;
	localparam logic [7:0]  ADDR_TICK    = 8'h82;

	// ****************************************
	// Reset values
	// ****************************************
	localparam logic [1:0]  RST_PAR      = 2'h0;
	localparam logic [11:0] RST_EN       = 12'h000;
	localparam logic        RST_CLKSRC   = 1'b0;
	localparam logic        RST_PHSEL    = 1'b0;
	localparam logic [3:0]  RST_DIV1     = 4'h7;
	localparam logic [3:0]  RST_DIV2     = 4'h7;

	typedef enum logic [1:0] {
		PSB_PAR_NONE = 2'h0,
		PSB_PAR_ONE  = 2'h1,
		PSB_PAR_TWO  = 2'h2,
		PSB_PAR_ALL  = 2'h3
	} psb_par_t;
endpackage : psb_pkg

// File: verification/phase_shift_bypass_pwm_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module phase_shift_bypass_pwm_tb_top
	import psb_pkg::*;
;
	logic        clk = 1'b0;
	logic        rst = 1'b1;
	logic [7:0]  reg_addr = 8'h00;
	logic [7:0]  reg_wdata = 8'h00;
	logic        reg_wr = 1'b0;
	logic        reg_rd = 1'b0;
	logic        ext_clk_pin = 1'b0;
	logic [11:0] led_open = 12'h000;
	logic [7:0]  reg_rdata;
	logic        reg_rvalid;
	logic [11:0] open_fault;
	logic [11:0] switch_on;
	logic [9:0]  period_count;
	int          n_fail = 0;
	int          n_checks = 0;
	int          on_cnt [12];
	int          fall_at [12];
	int          ph [12] = '{0, 360, 1000, 5, 7, 20, 100, 100, 100, 100, 100, 100};
	int          wd [12] = '{600, 600, 100, 0, 1023, 600, 300, 300, 300, 300, 300, 300};
	logic [11:0] en = 12'hfdf;

	psb_pwm DUT (.clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
		.ext_clk_pin(ext_clk_pin), .open_fault(open_fault), .switch_on(switch_on),
		.period_count(period_count));
	psb_sense_model u_sense (.clk(clk), .led_open(led_open), .switch_on(switch_on),
		.open_fault(open_fault));

	initial forever #5 clk = ~clk;
	// Pin high and low 4 cycles each, above the 2-cycle minimum
	initial forever begin
		repeat (4) @(negedge clk);
		ext_clk_pin = ~ext_clk_pin;
	end

	// ****************************************
	// Bus, measuring and closing tasks
	// ****************************************
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			n_fail++;
			$display("[FAIL] %0t got %0h expected %0h", $time, got, exp);
		end
	endtask : chk
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge clk);
		reg_addr = a;
		reg_wdata = d;
		reg_wr = 1'b1;
		@(negedge clk);
		reg_wr = 1'b0;
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [7:0] exp);
		@(negedge clk);
		reg_addr = a;
		reg_rd = 1'b1;
		@(negedge clk);
		reg_rd = 1'b0;
		chk(reg_rvalid, 1'b1);
		chk(reg_rdata, exp);
	endtask : rd
	// Skips two counter steps so a divider change has settled
	task automatic gap(input int exp);
		int n;
		logic [9:0] c;
		repeat (3) begin
			c = period_count;
			n = 0;
			while (period_count === c) begin
				@(negedge clk);
				n++;
			end
		end
		chk(n, exp);
	endtask : gap
	task automatic meas();
		logic [11:0] prev;
		repeat (1030) @(negedge clk);
		while (period_count !== 10'h000) @(negedge clk);
		prev = switch_on;
		for (int i = 0; i < 12; i++) begin
			on_cnt[i] = 0;
			fall_at[i] = -1;
		end
		repeat (1024) begin
			for (int i = 0; i < 12; i++) begin
				if (switch_on[i] === 1'b0) on_cnt[i]++;
				if (prev[i] && switch_on[i] === 1'b0) fall_at[i] = period_count;
			end
			prev = switch_on;
			@(negedge clk);
		end
	endtask : meas
	function automatic int duty(input int c, input logic m);
		if (!en[c] || wd[c] == 0) return 0;
		if (wd[c] == 1023) return 1024;
		return m ? wd[c] : wd[c] + 1;
	endfunction : duty
	function automatic int src(input int s, input int g);
		int b;
		b = s / 3;
		if (g == 3 || (g == 1 && b < 2)) b = 0;
		if (g == 2) b = b & 2;
		return 3 * b + s % 3;
	endfunction : src
	task automatic conclude();
		$display("checks %0d failures %0d", n_checks, n_fail);
		if (n_fail == 0 && n_checks > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask : conclude

	initial begin
		repeat (60000) @(posedge clk);
		n_fail++;
		$display("[FAIL] %0t watchdog expired", $time);
		conclude();
	end

	initial begin
		repeat (6) @(negedge clk);
		rst = 1'b0;
		rd(ADDR_PAR, 8'h00);
		rd(ADDR_EN_LO, 8'h00);
		rd(ADDR_EN_HI, 8'h00);
		rd(ADDR_CLKMODE, 8'h00);
		rd(ADDR_SYSTEM_CONFIGURATION, 8'h00);
		rd(ADDR_TICK, 8'h77);
		wr(8'h72, 8'hff);
		rd(8'h72, 8'h00);
		wr(8'h31, 8'h5a);
		rd(8'h31, 8'h00);
		wr(8'h03, 8'hff);
		rd(8'h03, 8'h03);
		$display("register test done");
		gap(64);
		wr(ADDR_TICK, 8'h21);
		gap(6);
		wr(ADDR_CLKMODE, 8'h01);
		gap(8);
		wr(ADDR_CLKMODE, 8'h00);
		wr(ADDR_TICK, 8'h00);
		gap(1);
		$display("base clock test done");
		for (int i = 0; i < 12; i++) begin
			wr(8'(4 * i), 8'(ph[i]));
			wr(8'(4 * i + 1), 8'(ph[i] >> 8));
			wr(8'(4 * i + 2), 8'(wd[i]));
			wr(8'(4 * i + 3), 8'(wd[i] >> 8));
		end
		wr(ADDR_EN_LO, en[7:0]);
		wr(ADDR_EN_HI, {4'h0, en[11:8]});
		for (int m = 1; m >= 0; m--) begin
			wr(ADDR_SYSTEM_CONFIGURATION, 8'(m));
			meas();
			for (int i = 0; i < 12; i++) chk(on_cnt[i], duty(i, m[0]));
			for (int i = 0; i < 3; i++) chk(fall_at[i], (ph[i] + (m ? 0 : 1023 - wd[i]) + 1) % 1024);
			$display("phase mode %0d test done", m);
		end
		wr(ADDR_SYSTEM_CONFIGURATION, 8'h01);
		led_open[0] = 1'b1;
		for (int g = 0; g < 4; g++) begin
			wr(ADDR_PAR, 8'(g));
			meas();
			for (int s = 0; s < 12; s++) chk(on_cnt[s], src(s, g) == 0 ? 0 : duty(src(s, g), 1'b1));
			$display("grouping %0d test done", g);
		end
		conclude();
	end
endmodule : phase_shift_bypass_pwm_tb_top
`default_nettype wire

// File: verification/psb_pwm_props.sv
`timescale 1ns/1ps
`default_nettype none
module psb_pwm_props
	import psb_pkg::*;
(
	input  wire logic        clk,          // Clock
	input  wire logic        rst,          // Reset
	input  wire logic [7:0]  reg_addr,     // Address
	input  wire logic [7:0]  reg_wdata,    // Write data
	input  wire logic        reg_wr,       // Write strobe
	input  wire logic        reg_rd,       // Read strobe
	input  wire logic [7:0]  reg_rdata,    // Read data
	input  wire logic        reg_rvalid,   // Read valid
	input  wire logic        ext_clk_pin,  // Base clock pin
	input  wire logic [11:0] open_fault,   // Open sense
	input  wire logic [11:0] switch_on,    // Gate command
	input  wire logic [9:0]  period_count  // Counter
);
	// Shadow of the grouping, fed from the bus only
	logic [1:0] par;
	always_ff @(posedge clk) begin
		if (rst) begin
			par <= 2'h0;
		end else if (reg_wr && reg_addr == ADDR_PAR) begin
			par <= reg_wdata[1:0];
		end
	end
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);
	a_cnt_clear: assert property ($fell(rst) |-> period_count == 10'h000)
		else $error("counter not cleared by reset");
	a_cnt_step: assert property (!$stable(period_count) && !$past(rst) |->
		period_count == $past(period_count) + 10'h001)
		else $error("counter skipped a value");
	a_sw_reset: assert property ($fell(rst) |-> switch_on == 12'hfff)
		else $error("switch off while channels disabled");
	a_rd_valid: assert property (reg_rd |=> reg_rvalid)
		else $error("read not answered");
	a_rd_idle: assert property (!reg_rvalid |-> reg_rdata == 8'h00)
		else $error("read data outside valid");
	a_rd_group: assert property (reg_rd && reg_addr == ADDR_PAR |=>
		reg_rdata == {6'h00, $past(par)})
		else $error("grouping readback wrong");
	a_fault_own: assert property (open_fault[0] [*6] |-> switch_on[0])
		else $error("faulty switch not turned on");
	a_fault_pair: assert property ((open_fault[0] && par != 2'h0) [*6] |-> switch_on[3])
		else $error("paired switch not turned on");
	a_fault_all: assert property ((open_fault[0] && par == 2'h3) [*6] |-> switch_on[9])
		else $error("group member not turned on");
endmodule : psb_pwm_props
bind psb_pwm psb_pwm_props u_props (.clk(clk), .rst(rst), .reg_addr(reg_addr),
	.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
	.reg_rvalid(reg_rvalid), .ext_clk_pin(ext_clk_pin), .open_fault(open_fault),
	.switch_on(switch_on), .period_count(period_count));
`default_nettype wire

// File: verification/psb_sense_model.sv
`timescale 1ns/1ps
`default_nettype none
module psb_sense_model
	import psb_pkg::*;
(
	input  wire logic        clk,        // Clock
	input  wire logic [11:0] led_open,   // LED physically open
	input  wire logic [11:0] switch_on,  // Gate command
	output logic      [11:0] open_fault  // Sensed open
);
	// Open LED only shows while its switch is off; latched until repaired
	logic [11:0] sensed = 12'h000;
	always_ff @(posedge clk) begin
		sensed <= led_open & (sensed | ~switch_on);
	end
	assign open_fault = sensed;
endmodule : psb_sense_model
`default_nettype wire

// File: verilog/psb_pwm.sv
// Contract
// - Disabled or zero-width channel keeps on the switches that follow it
// - Four bank groupings: none, one, two, all
// - Grouping resets to all banks independent
// - Paralleled switches toggle and fault together
// - Synchronised open fault turns the same position in every bank of the group on
// - Phase and width registers per channel
// - Ten-bit counter wraps 1023 to 0 per tick
// - Base clock from divider or clock pin
// - Two cascaded dividers set by tick register
// - Phase-mode bit picks turn-on or turn-off edge
// - Mode one: LED on at phase, off at phase+width
// - Mode zero: LED off at phase, on later
// - Period is 1024 base clock ticks
// - Width zero gives zero duty
// - Width 1023 gives full duty
// - Counter cleared to zero at reset
`timescale 1ns/1ps
`default_nettype none
module psb_pwm
	import psb_pkg::*;
(
	input  wire logic        clk,          // Internal oscillator clock
	input  wire logic        rst,          // Synchronous reset
	input  wire logic [7:0]  reg_addr,     // Register address
	input  wire logic [7:0]  reg_wdata,    // Write data
	input  wire logic        reg_wr,       // Write strobe
	input  wire logic        reg_rd,       // Read strobe
	output logic      [7:0]  reg_rdata,    // Read data
	output logic             reg_rvalid,   // Read data valid
	input  wire logic        ext_clk_pin,  // External base clock pin
	input  wire logic [11:0] open_fault,   // LED open sense per switch
	output logic      [11:0] switch_on,    // Bypass gate: 1 = LED dark
	output logic      [9:0]  period_count  // Period counter
);
	// ****************************************
	// State
	// ****************************************
	typedef struct packed {
		logic [NUM_CH-1:0][9:0] phase;
		logic [NUM_CH-1:0][9:0] width;
		logic [11:0]            enable;
		logic [1:0]             grouping;
		logic                   clk_src;
		logic                   phase_sel;
		logic [3:0]             div1;
		logic [3:0]             div2;
		logic [9:0]             counter;
		logic [NUM_CH-1:0]      led_on;
		logic [11:0]            sw_on;
		logic [2:0]             pin_sync;
		logic                   pin_stable;
		logic [NUM_CH-1:0]      flt_s1;
		logic [NUM_CH-1:0]      flt_s2;
		logic [NUM_CH-1:0]      flt_s3;
		logic [NUM_CH-1:0]      flt_stable;
		logic [7:0]             rdata;
		logic                   rvalid;
	} psb_st_t;

	psb_st_t st;
	psb_st_t next_st;
	logic    div_tick;

	psb_tick_div u_div (
		.clk  (clk),
		.rst  (rst),
		.div1 (st.div1),
		.div2 (st.div2),
		.tick (div_tick)
	);

	// ****************************************
	// Helpers
	// ****************************************
	// Lowest bank of the parallel group that holds bank b
	function automatic logic [1:0] lead_bank(input logic [1:0] grp, input logic [1:0] b);
		logic [1:0] r;
		r = b;
		unique case (psb_par_t'(grp))
			PSB_PAR_NONE: r = b;
			PSB_PAR_ONE:  r = (b <= 2'd1) ? 2'd0 : b;
			PSB_PAR_TWO:  r = {b[1], 1'b0};
			PSB_PAR_ALL:  r = 2'd0;
		endcase
		return r;
	endfunction : lead_bank

	function automatic logic [7:0] read_reg(input psb_st_t s, input logic [7:0] a);
		logic [7:0] r;
		logic [3:0] ch;
		r  = 8'h00;
		ch = a[5:2];
		if (a < ADDR_CH_END) begin
			unique case (a[1:0])
				FLD_PH_LO: r = s.phase[ch][7:0];
				FLD_PH_HI: r = {6'h00, s.phase[ch][9:8]};
				FLD_WD_LO: r = s.width[ch][7:0];
				FLD_WD_HI: r = {6'h00, s.width[ch][9:8]};
			endcase
		end else begin
			unique case (a)
				ADDR_PAR:     r = {6'h00, s.grouping};
				ADDR_EN_LO:   r = s.enable[7:0];
				ADDR_EN_HI:   r = {4'h0, s.enable[11:8]};
				ADDR_CLKMODE: r = {7'h00, s.clk_src};
				ADDR_SYSTEM_CONFIGURATION:  r = {7'h00, s.phase_sel};
				ADDR_TICK:    r = {s.div2, s.div1};
				default:      r = 8'h00;
			endcase
		end
		return r;
	endfunction : read_reg

	// ****************************************
	// Next state
	// ****************************************
	logic       base_tick;
	logic [3:0] wch;
	logic [1:0] lb;
	logic [3:0] src;
	logic [9:0] ph;
	logic [9:0] wd;
	logic [9:0] edge2;
	logic       grp_fault;
	logic       idle;

	always_comb begin
		next_st    = st;
		base_tick  = 1'b0;
		wch        = reg_addr[5:2];
		lb         = 2'd0;
		src        = 4'd0;
		ph         = 10'h000;
		wd         = 10'h000;
		edge2      = 10'h000;
		grp_fault  = 1'b0;
		idle       = 1'b0;

		// Register writes
		if (reg_wr) begin
			if (reg_addr < ADDR_CH_END) begin
				unique case (reg_addr[1:0])
					FLD_PH_LO: next_st.phase[wch][7:0] = reg_wdata;
					FLD_PH_HI: next_st.phase[wch][9:8] = reg_wdata[1:0];
					FLD_WD_LO: next_st.width[wch][7:0] = reg_wdata;
					FLD_WD_HI: next_st.width[wch][9:8] = reg_wdata[1:0];
				endcase
			end else begin
				unique case (reg_addr)
					ADDR_PAR:     next_st.grouping  = reg_wdata[1:0];
					ADDR_EN_LO:   next_st.enable[7:0] = reg_wdata;
					ADDR_EN_HI:   next_st.enable[11:8] = reg_wdata[3:0];
					ADDR_CLKMODE: next_st.clk_src   = reg_wdata[0];
					ADDR_SYSTEM_CONFIGURATION:  next_st.phase_sel = reg_wdata[0];
					ADDR_TICK: begin
						next_st.div1 = reg_wdata[3:0];
						next_st.div2 = reg_wdata[7:4];
					end
					default: ;
				endcase
			end
		end

		// Register reads answer one cycle later
		next_st.rvalid = reg_rd;
		next_st.rdata  = reg_rd ? read_reg(st, reg_addr) : 8'h00;

		// Clock pin: stable level moves only when stages two and three agree
		next_st.pin_sync = {st.pin_sync[1:0], ext_clk_pin};
		if (st.pin_sync[1] == st.pin_sync[2]) begin
			next_st.pin_stable = st.pin_sync[2];
		end

		// Base clock select
		if (st.clk_src) begin
			base_tick = next_st.pin_stable & ~st.pin_stable;
		end else begin
			base_tick = div_tick;
		end

		// Free-running period counter, 1024 ticks per period
		if (base_tick) begin
			next_st.counter = (st.counter == CNT_MAX) ? 10'h000 : st.counter + 10'h001;
		end

		// Fault synchronisers, same agreement filter as the pin
		next_st.flt_s1 = open_fault;
		next_st.flt_s2 = st.flt_s1;
		next_st.flt_s3 = st.flt_s2;
		for (int i = 0; i < NUM_CH; i++) begin
			if (st.flt_s2[i] == st.flt_s3[i]) begin
				next_st.flt_stable[i] = st.flt_s3[i];
			end
		end

		// Per-switch PWM, paralleled switches follow their group lead
		for (int c = 0; c < NUM_CH; c++) begin
			lb  = lead_bank(st.grouping, 2'(c / CH_PER_BANK));
			src = 4'(lb * CH_PER_BANK + c % CH_PER_BANK);
			ph  = st.phase[src];
			wd  = st.width[src];
			idle = ~st.enable[src] | (wd == WIDTH_ZERO);
			if (idle) begin
				next_st.led_on[c] = 1'b0;
			end else if (wd == WIDTH_FULL) begin
				next_st.led_on[c] = 1'b1;
			end else if (st.phase_sel) begin
				edge2 = ph + wd;
				if (st.counter == ph) begin
					next_st.led_on[c] = 1'b1;
				end else if (st.counter == edge2) begin
					next_st.led_on[c] = 1'b0;
				end
			end else begin
				edge2 = ph + CNT_MAX - wd;
				if (st.counter == ph) begin
					next_st.led_on[c] = 1'b0;
				end else if (st.counter == edge2) begin
					next_st.led_on[c] = 1'b1;
				end
			end

			// Any open fault in the group forces the same position on
			grp_fault = 1'b0;
			for (int b = 0; b < NUM_BANK; b++) begin
				if (lead_bank(st.grouping, 2'(b)) == lb &&
				    st.flt_stable[b * CH_PER_BANK + c % CH_PER_BANK]) begin
					grp_fault = 1'b1;
				end
			end
			next_st.sw_on[c] = ~next_st.led_on[c] | grp_fault;
		end
	end

	// ****************************************
	// Registers
	// ****************************************
	always_ff @(posedge clk) begin
		if (rst) begin
			st           <= '0;
			st.grouping  <= RST_PAR;
			st.enable    <= RST_EN;
			st.clk_src   <= RST_CLKSRC;
			st.phase_sel <= RST_PHSEL;
			st.div1      <= RST_DIV1;
			st.div2      <= RST_DIV2;
			st.counter   <= 10'h000;
			st.sw_on     <= 12'hfff;
		end else begin
			st <= next_st;
		end
	end

	assign switch_on    = st.sw_on;
	assign period_count = st.counter;
	assign reg_rdata    = st.rdata;
	assign reg_rvalid   = st.rvalid;
endmodule : psb_pwm
`default_nettype wire

// File: verilog/psb_tick_div.sv
`timescale 1ns/1ps
`default_nettype none
module psb_tick_div
	import psb_pkg::*;
(
	input  wire logic       clk,        // Oscillator clock
	input  wire logic       rst,        // Synchronous reset
	input  wire logic [3:0] div1,       // First divider field
	input  wire logic [3:0] div2,       // Second divider field
	output logic            tick        // One-cycle base pulse
);
	typedef struct packed {
		logic [3:0] c1;
		logic [3:0] c2;
		logic       tick;
	} psb_div_st_t;

	psb_div_st_t st;
	psb_div_st_t next_st;

	// Ratio is (div1+1)*(div2+1)
	always_comb begin
		next_st      = st;
		next_st.tick = 1'b0;
		if (st.c1 >= div1) begin
			next_st.c1 = 4'h0;
			if (st.c2 >= div2) begin
				next_st.c2   = 4'h0;
				next_st.tick = 1'b1;
			end else begin
				next_st.c2 = st.c2 + 4'h1;
			end
		end else begin
			next_st.c1 = st.c1 + 4'h1;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	assign tick = st.tick;
endmodule : psb_tick_div
`default_nettype wire
